// ==== design/gpio_pkg.sv ====
/*
  package for the three-port gpio block: register offsets, reset values,
  widths and bus response codes.
  assumes a 32-bit axi4-lite register bus with one register per word.
*/
package gpio_pkg;
  // printed offsets are register indices; byte address is four times
  localparam logic [7:0] IDX_PORT0_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] IDX_PORT1_DATA = 8'h01;
  localparam logic [7:0] IDX_PORT2_OUTPUT_LATCH = 8'h02;
  localparam logic [7:0] IDX_PORT0_DRIVE_TYPE = 8'h08;
  localparam logic [7:0] IDX_PORT1_DIRECTION = 8'h09;
  localparam logic [7:0] IDX_PORT0_PIN_LEVEL = 8'h0b;
  localparam logic [7:0] IDX_PORT2_PIN_LEVEL = 8'h0c;
  // control bits for clock mode and stop mode (own register)
  localparam logic [7:0] IDX_MODE_CTRL = 8'h20;
  // external interrupt latch for port two pin zero (own register)
  localparam logic [7:0] IDX_PIN0_EVENT = 8'h21;
  localparam int MODE_DUAL_CLOCK_BIT = 0;
  localparam int MODE_STOP_BIT = 1;
  // reset values
  localparam logic [7:0] RST_PORT0_LATCH = 8'hff;
  localparam logic [7:0] RST_PORT0_DRIVE = 8'h00;
  localparam logic [7:0] RST_PORT1_LATCH = 8'h00;
  localparam logic [7:0] RST_PORT1_DIR = 8'h00;
  localparam logic [2:0] RST_PORT2_LATCH = 3'h7;
  localparam logic [1:0] RST_MODE = 2'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== design/pin_sync.sv ====
/*
  three-stage synchroniser for a group of pin inputs.
  a change counts once the second and third stage agree; the first
  stage feeds only the second.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] async_i,
  input wire logic [WIDTH-1:0] rst_val_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_q; // metastability catcher
  logic [WIDTH-1:0] s2_q; // second stage
  logic [WIDTH-1:0] s3_q; // third stage

  // shift chain, no reset on the raw stages
  always_ff @(posedge ref_clk_i)
  begin
    s1_q <= async_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // accept a bit only when stages two and three agree
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      level_o <= rst_val_i;
    end
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// ==== design/gpio_ports.sv ====
/*
  parallel i/o logic for three ports behind an axi4-lite register slave:
  port zero with per-bit open-drain or push-pull drive, port one with
  per-bit direction, port two with crystal pins and a stop-release pin.
  assumes pins are resolved outside from out/oe pairs; pin inputs are
  asynchronous and pass a synchroniser.
*/
`timescale 1ns/1ps
module gpio_ports
  import gpio_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port zero pins
  input wire logic [7:0] port0_pin_i,
  output logic [7:0] port0_pin_o,
  output logic [7:0] port0_pin_oe_o,
  // port one pins
  input wire logic [7:0] port1_pin_i,
  output logic [7:0] port1_pin_o,
  output logic [7:0] port1_pin_oe_o,
  // port two pins
  input wire logic [2:0] port2_pin_i,
  output logic [2:0] port2_pin_o,
  output logic [2:0] port2_pin_oe_o,
  // crystal handover and interrupt latch state
  output logic xtal_pins_claimed_o,
  output logic pin0_event_o
);
  logic [7:0] port0_output_latch_q; // port zero latch
  logic [7:0] port0_drive_type_q; // 1 = push-pull
  logic [7:0] port1_data_q; // port one latch
  logic [7:0] port1_direction_q; // 1 = output
  logic [2:0] port2_output_latch_q; // port two latch
  logic [1:0] mode_q; // dual-clock and stop bits
  logic pin0_event_q; // interrupt latch for pin zero
  logic pin0_drv_prev_q; // last driven level of pin zero
  logic [7:0] p0_lvl; // synchronised levels
  logic [7:0] p1_lvl;
  logic [2:0] p2_lvl;
  logic have_aw_q; // write address captured
  logic have_w_q; // write data captured
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go; // both halves present
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic pin0_drv; // pin zero actively low output
  logic pin0_oe;

  // byte address to register index, dropping the word offset
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[9:2];
  endfunction

  // decoded index of a mapped register
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == IDX_PORT0_OUTPUT_LATCH) || (i == IDX_PORT1_DATA) ||
                (i == IDX_PORT2_OUTPUT_LATCH) ||
                (i == IDX_PORT0_DRIVE_TYPE) ||
                (i == IDX_PORT1_DIRECTION) ||
                (i == IDX_PORT0_PIN_LEVEL) ||
                (i == IDX_PORT2_PIN_LEVEL) ||
                (i == IDX_MODE_CTRL) || (i == IDX_PIN0_EVENT);
  endfunction

  pin_sync #(.WIDTH(19)) u_sync (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .async_i({port2_pin_i, port1_pin_i, port0_pin_i}),
    .rst_val_i(19'h0_0000),
    .level_o({p2_lvl, p1_lvl, p0_lvl})
  );

  assign wr_go = have_aw_q && have_w_q && !s_axi_bvalid;
  assign wr_idx = reg_index(awaddr_q);
  assign rd_idx = reg_index(s_axi_araddr);
  // accept each half once, in either order
  assign s_axi_awready = !have_aw_q && !s_axi_bvalid;
  assign s_axi_wready = !have_w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // capture write address and data independently
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else if (wr_go)
    begin
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        have_aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        have_w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // write response, slverr for unmapped or read-only words
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      if (is_mapped(wr_idx) && wr_idx != IDX_PORT0_PIN_LEVEL &&
          wr_idx != IDX_PORT2_PIN_LEVEL)
        s_axi_bresp <= RESP_OKAY;
      else
        s_axi_bresp <= RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes; only byte lane zero carries data
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      port0_output_latch_q <= RST_PORT0_LATCH;
      port0_drive_type_q <= RST_PORT0_DRIVE;
      port1_data_q <= RST_PORT1_LATCH;
      port1_direction_q <= RST_PORT1_DIR;
      port2_output_latch_q <= RST_PORT2_LATCH;
      mode_q <= RST_MODE;
    end
    else if (wr_go && wstrb_q[0])
    begin
      case (wr_idx)
        IDX_PORT0_OUTPUT_LATCH: port0_output_latch_q <= wdata_q[7:0];
        IDX_PORT0_DRIVE_TYPE: port0_drive_type_q <= wdata_q[7:0];
        // written value lands in every latch bit
        IDX_PORT1_DATA: port1_data_q <= wdata_q[7:0];
        IDX_PORT1_DIRECTION: port1_direction_q <= wdata_q[7:0];
        IDX_PORT2_OUTPUT_LATCH: port2_output_latch_q <= wdata_q[2:0];
        IDX_MODE_CTRL: mode_q <= wdata_q[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      pin0_event_q <= 1'b0;
      pin0_drv_prev_q <= 1'b1;
    end
    else
    begin
      pin0_drv_prev_q <= port2_pin_o[0] | ~pin0_oe;
      // set wins over a clear in the same cycle
      if (pin0_drv_prev_q && pin0_drv)
        pin0_event_q <= 1'b1;
      else if (wr_go && wstrb_q[0] && wr_idx == IDX_PIN0_EVENT &&
               wdata_q[0])
        pin0_event_q <= 1'b0;
    end
  end

  // read channel, one register-stage answer
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata <= 32'h0000_0000;
      case (rd_idx)
        IDX_PORT0_OUTPUT_LATCH: s_axi_rdata[7:0] <= port0_output_latch_q;
        IDX_PORT0_PIN_LEVEL: s_axi_rdata[7:0] <= p0_lvl;
        IDX_PORT0_DRIVE_TYPE: s_axi_rdata[7:0] <= port0_drive_type_q;
        IDX_PORT1_DATA: s_axi_rdata[7:0] <=
          (port1_data_q & port1_direction_q) |
          (p1_lvl & ~port1_direction_q);
        IDX_PORT1_DIRECTION: s_axi_rdata[7:0] <= port1_direction_q;
        // latch and pins apart; upper bits read zero
        IDX_PORT2_OUTPUT_LATCH: s_axi_rdata[2:0] <= port2_output_latch_q;
        IDX_PORT2_PIN_LEVEL: s_axi_rdata[2:0] <= p2_lvl;
        IDX_MODE_CTRL: s_axi_rdata[1:0] <= mode_q;
        IDX_PIN0_EVENT: s_axi_rdata[0] <= pin0_event_q;
        default: ;
      endcase
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // port zero drivers: open-drain only pulls low
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      port0_pin_o[i] = port0_output_latch_q[i];
      port0_pin_oe_o[i] = port0_drive_type_q[i] |
                          ~port0_output_latch_q[i];
    end
  end

  assign port1_pin_o = port1_data_q;
  assign port1_pin_oe_o = port1_direction_q;

  assign pin0_oe = ~mode_q[MODE_STOP_BIT] & ~port2_output_latch_q[0];
  assign pin0_drv = pin0_oe;
  assign xtal_pins_claimed_o = mode_q[MODE_DUAL_CLOCK_BIT];

  // port two is sink-only, so only a zero latch drives
  always_comb
  begin
    port2_pin_o = port2_output_latch_q;
    port2_pin_oe_o[0] = pin0_oe;
    port2_pin_oe_o[2:1] = mode_q[MODE_DUAL_CLOCK_BIT] ? 2'b00 :
                          ~port2_output_latch_q[2:1];
  end

  assign pin0_event_o = pin0_event_q;
endmodule

// ==== bench/gpio_ports_properties.sv ====
/*
  checker for the three-port gpio block: write answer, reset state,
  pin drive and output timing.
  assumes it is bound to gpio_ports and sees only its ports.
*/
`timescale 1ns/1ps
module gpio_ports_properties (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] port0_pin_o,
  input wire logic [7:0] port0_pin_oe_o,
  input wire logic [7:0] port1_pin_o,
  input wire logic [7:0] port1_pin_oe_o,
  input wire logic [2:0] port2_pin_o,
  input wire logic [2:0] port2_pin_oe_o,
  input wire logic xtal_pins_claimed_o,
  input wire logic pin0_event_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // both halves of a write taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // first edge out of reset
  sequence s_rst_out;
    $fell(srst_i);
  endsequence
  // pin outputs move only with a write answer
  sequence s_wr_done;
    $rose(s_axi_bvalid);
  endsequence
  property p_wr_answer;
    s_wr_taken |-> ##[1:3] s_axi_bvalid;
  endproperty
  property p_rst_p0;
    s_rst_out |-> port0_pin_o == 8'hff && port0_pin_oe_o == 8'h00;
  endproperty
  property p_rst_p1;
    s_rst_out |-> port1_pin_o == 8'h00 && port1_pin_oe_o == 8'h00;
  endproperty
  property p_rst_p2;
    s_rst_out |-> port2_pin_o == 3'h7 && !pin0_event_o;
  endproperty
  property p_od_low;
    (~port0_pin_o & ~port0_pin_oe_o) == 8'h00;
  endproperty
  property p_p0_write;
    $changed({port0_pin_o, port0_pin_oe_o}) |-> s_wr_done;
  endproperty
  property p_p1_write;
    $changed({port1_pin_o, port1_pin_oe_o}) |-> s_wr_done;
  endproperty
  property p_p2_write;
    $changed({port2_pin_o, xtal_pins_claimed_o}) |-> s_wr_done;
  endproperty
  property p_xtal;
    xtal_pins_claimed_o |-> port2_pin_oe_o[2:1] == 2'b00;
  endproperty
  property p_fall_event;
    $rose(port2_pin_oe_o[0]) && !port2_pin_o[0] |-> ##[0:2] pin0_event_o;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer late");
  a_rst_p0: assert property (p_rst_p0)
    else $error("port0 reset state wrong");
  a_rst_p1: assert property (p_rst_p1)
    else $error("port1 reset state wrong");
  a_rst_p2: assert property (p_rst_p2)
    else $error("port2 reset state wrong");
  a_od_low: assert property (p_od_low)
    else $error("port0 zero not driven");
  a_p0_write: assert property (p_p0_write)
    else $error("port0 moved without write");
  a_p1_write: assert property (p_p1_write)
    else $error("port1 moved without write");
  a_p2_write: assert property (p_p2_write)
    else $error("port2 moved without write");
  a_xtal: assert property (p_xtal)
    else $error("crystal pins driven");
  a_fall_event: assert property (p_fall_event)
    else $error("falling pin0 not latched");
endmodule

bind gpio_ports gpio_ports_properties gpio_ports_properties_inst (.*);

// ==== bench/pin_board.sv ====
/*
  board model for one port: pull-up on every line plus an optional
  external driver per line.
  assumes the bench never drives a line the block drives.
*/
`timescale 1ns/1ps
module pin_board #(
  parameter int W = 8
) (
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] ext_val_i,
  input wire logic [W-1:0] ext_en_i,
  output logic [W-1:0] level_o
);
  assign level_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
    | (~oe_i & ~ext_en_i);
endmodule

// ==== bench/gpio_ports_tb_top.sv ====
/*
  self-checking bench for the three-port gpio block.
  assumes the board model and a bound checker; seed fixed.
*/
`timescale 1ns/1ps
module gpio_ports_tb_top;
  import gpio_pkg::*;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, xtal_pins_claimed_o, pin0_event_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [7:0] port0_pin_i, port0_pin_o, port0_pin_oe_o;
  logic [7:0] port1_pin_i, port1_pin_o, port1_pin_oe_o;
  logic [2:0] port2_pin_i, port2_pin_o, port2_pin_oe_o;
  logic [7:0] ext0_v = 0, ext0_e = 0, ext1_v = 0, ext1_e = 0;
  logic [2:0] ext2_v = 0, ext2_e = 0;
  logic [31:0] seed = 32'h0001_084b, rv;
  logic [7:0] l, d, e, v;
  int bad_count = 0, samples_checked = 0, cycles = 0;

  gpio_ports gpio_ports_inst (.*);
  pin_board #(.W(8)) board0 (.out_i(port0_pin_o), .oe_i(port0_pin_oe_o),
    .ext_val_i(ext0_v), .ext_en_i(ext0_e), .level_o(port0_pin_i));
  pin_board #(.W(8)) board1 (.out_i(port1_pin_o), .oe_i(port1_pin_oe_o),
    .ext_val_i(ext1_v), .ext_en_i(ext1_e), .level_o(port1_pin_i));
  pin_board #(.W(3)) board2 (.out_i(port2_pin_o), .oe_i(port2_pin_oe_o),
    .ext_val_i(ext2_v), .ext_en_i(ext2_e), .level_o(port2_pin_i));

  always #10 ref_clk_i = ~ref_clk_i;

  // hang guard, far above the expected run
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // expected pin level: driven, else external, else pull-up
  function automatic logic [31:0] lvl(input logic [7:0] o, oe, en, val);
    return {24'h0, (oe & o) | (~oe & en & val) | (~oe & ~en)};
  endfunction

  task automatic chk(input logic [31:0] g, x);
    samples_checked++;
    if (g !== x)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] i, input logic [31:0] dd);
    logic done;
    done = 0;
    @(posedge ref_clk_i);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!done)
    begin
      // read handshakes at the edge, before the design's updates land
      @(posedge ref_clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      done = s_axi_bvalid;
      rr = s_axi_bresp;
    end
    s_axi_bready <= 0;
  endtask

  // read: address held until taken, data taken at the rvalid edge
  task automatic rd(input logic [7:0] i);
    logic done;
    done = 0;
    @(posedge ref_clk_i);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!done)
    begin
      @(posedge ref_clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      done = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
    end
    s_axi_rready <= 0;
  endtask

  task automatic rc(input logic [7:0] i, input logic [31:0] x);
    rd(i);
    chk(rv, x);
  endtask

  task automatic wrap_up();
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    srst_i <= 0;
    repeat (4) @(posedge ref_clk_i);
    rc(IDX_PORT0_OUTPUT_LATCH, 32'h0000_00ff);
    rc(IDX_PORT0_DRIVE_TYPE, 32'h0000_0000);
    rc(IDX_PORT1_DIRECTION, 32'h0000_0000);
    rc(IDX_PORT1_DATA, 32'h0000_00ff);
    rc(IDX_PORT2_OUTPUT_LATCH, 32'h0000_0007);
    rc(IDX_PORT0_PIN_LEVEL, 32'h0000_00ff);
    $display("done: reset state");
    repeat (4)
    begin
      seed = xs(seed);
      {v, e, d, l} = seed;
      e = e & ~(d | ~l);
      ext0_e <= e;
      ext0_v <= v;
      wr(IDX_PORT0_OUTPUT_LATCH, {24'h0, l});
      wr(IDX_PORT0_DRIVE_TYPE, {24'h0, d});
      repeat (5) @(posedge ref_clk_i);
      rc(IDX_PORT0_OUTPUT_LATCH, {24'h0, l});
      rc(IDX_PORT0_PIN_LEVEL, lvl(l, d | ~l, e, v));
    end
    $display("done: port0 drive");
    repeat (4)
    begin
      seed = xs(seed);
      {v, e, d, l} = seed;
      e = e & ~d;
      ext1_e <= e;
      ext1_v <= v;
      wr(IDX_PORT1_DATA, {24'h0, l});
      wr(IDX_PORT1_DIRECTION, {24'h0, d});
      repeat (5) @(posedge ref_clk_i);
      rc(IDX_PORT1_DATA, lvl(l, d, e, v));
      wr(IDX_PORT1_DATA, rv);
      ext1_e <= 0;
      wr(IDX_PORT1_DIRECTION, 32'h0000_00ff);
      rc(IDX_PORT1_DATA, lvl(l, d, e, v));
    end
    $display("done: port1 direction");
    // latch ones before the pins serve as inputs
    wr(IDX_PORT2_OUTPUT_LATCH, 32'h0000_0007);
    ext2_e <= 3'b110;
    ext2_v <= 3'b010;
    repeat (5) @(posedge ref_clk_i);
    rd(IDX_PORT2_PIN_LEVEL);
    chk(rv & 32'h0000_0007, 32'h0000_0003);
    ext2_e <= 0;
    wr(IDX_PIN0_EVENT, 32'h0000_0001);
    // all-zero latch: pin zero falls, upper pins driven low
    wr(IDX_PORT2_OUTPUT_LATCH, 32'h0000_0000);
    // outputs launched at the answer edge settle by the falling edge
    @(negedge ref_clk_i);
    chk(32'(pin0_event_o), 32'h0000_0001);
    wr(IDX_PIN0_EVENT, 32'h0000_0001);
    @(negedge ref_clk_i);
    chk(32'(pin0_event_o), 32'h0000_0000);
    wr(IDX_MODE_CTRL, 32'h0000_0002);
    @(negedge ref_clk_i);
    chk(32'(port2_pin_oe_o), 32'h0000_0006);
    wr(IDX_MODE_CTRL, 32'h0000_0001);
    @(negedge ref_clk_i);
    chk(32'({xtal_pins_claimed_o, port2_pin_oe_o}), 32'h0000_0009);
    wr(IDX_MODE_CTRL, 32'h0000_0000);
    @(negedge ref_clk_i);
    chk(32'({xtal_pins_claimed_o, port2_pin_oe_o}), 32'h0000_0007);
    $display("done: port2 modes");
    wr(IDX_PORT0_PIN_LEVEL, 32'h0000_0000);
    chk(32'(rr), 32'(RESP_SLVERR));
    rd(8'h30);
    chk(32'(rr), 32'(RESP_SLVERR));
    $display("done: refused access");
    wrap_up();
  end
endmodule
